// >>> src/acp_pkg.sv
// shared constants and types for the converter control block
package acp_pkg;
  localparam int unsigned RESULT_WIDTH  = 8;
  localparam int unsigned CHAN_WIDTH    = 3;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // conversion time, longest figure, rounded down
  localparam int unsigned CONV_TIME_NS  = 420;
  localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  // hold interval before returning to track, rounded down, at least one
  localparam int unsigned HOLD_TIME_NS  = 120;
  localparam int unsigned HOLD_CYCLES_RAW = HOLD_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYCLES   = (HOLD_CYCLES_RAW < 1) ? 1 : HOLD_CYCLES_RAW;
  // end-of-conversion pulse width, least figure, rounded up
  localparam int unsigned EOC_TIME_NS   = 70;
  localparam int unsigned EOC_CYCLES    = (EOC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_WIDTH     = 4;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE  = 4'h1;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 8'h00;
  localparam logic [CHAN_WIDTH-1:0]   CHAN_RESET   = 3'h0;
  localparam logic [CNT_WIDTH-1:0] CONV_LOAD = CNT_WIDTH'(CONV_CYCLES);
  localparam logic [CNT_WIDTH-1:0] HOLD_LOAD = CNT_WIDTH'(HOLD_CYCLES);
  localparam logic [CNT_WIDTH-1:0] EOC_LOAD  = CNT_WIDTH'(EOC_CYCLES);

  typedef enum logic [1:0] {
    ACP_IDLE,
    ACP_CONVERT,
    ACP_EOC
  } acp_state_type;
endpackage

// >>> src/acp_port_if.sv
// interface between the converter core and the parallel read port
`timescale 1ns/10ps
interface acp_port_if;
  logic [acp_pkg::RESULT_WIDTH-1:0] heldResult;
  modport core (output heldResult);
  modport port (input heldResult);
endinterface

// >>> src/acp_read_port.sv
// parallel read port: chip select gating and result output enable
`timescale 1ns/10ps
module acp_read_port (
  input  wire logic                             ref_clk,
  input  wire logic                             rstSync_b,
  input  wire logic                             chipSel_n,
  input  wire logic                             readStrobe_n,
  input  wire logic [acp_pkg::CHAN_WIDTH-1:0]   channel_sel,
  acp_port_if.port                              portIf,
  output logic      [acp_pkg::RESULT_WIDTH-1:0] resultOut,
  output logic                                  resultOe,
  output logic      [acp_pkg::CHAN_WIDTH-1:0]   chanSelected
);
  logic                           readActive;
  logic                           readActive_reg;
  logic                           readFall;
  logic [acp_pkg::CHAN_WIDTH-1:0] chan_reg;

  // port only answers while both strobes are low
  assign readActive       = ~chipSel_n & ~readStrobe_n;
  assign readFall         = readActive & ~readActive_reg;
  assign resultOe         = readActive;
  assign resultOut        = portIf.heldResult;
  assign chanSelected     = chan_reg;

  // channel address caught as the read begins
  always_ff @(posedge ref_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      readActive_reg <= 1'b0;
      chan_reg       <= acp_pkg::CHAN_RESET;
    end
    else
    begin
      readActive_reg <= readActive;
      if (readFall)
        chan_reg <= channel_sel;
    end
  end
endmodule // acp_read_port

// >>> src/acp_converter.sv
// converter control: start, track/hold, end of conversion, power-down
`timescale 1ns/10ps
module acp_converter (
  input  wire logic                             ref_clk,
  input  wire logic                             rst_b,
  input  wire logic                             convert_start_n,
  input  wire logic                             sleep_n,
  input  wire logic                             chipSel_n,
  input  wire logic                             readStrobe_n,
  input  wire logic [acp_pkg::CHAN_WIDTH-1:0]   channel_sel,
  input  wire logic [acp_pkg::RESULT_WIDTH-1:0] sampleCode,
  output logic                                  eocOut_n,
  output logic      [acp_pkg::RESULT_WIDTH-1:0] resultOut,
  output logic                                  resultOe,
  output logic                                  holdMode,
  output logic                                  poweredDown,
  output logic      [acp_pkg::CHAN_WIDTH-1:0]   chanSelected
);
  // local copies of package widths, so size casts name a plain identifier
  localparam int unsigned RW = acp_pkg::RESULT_WIDTH;
  localparam int unsigned CW = acp_pkg::CNT_WIDTH;

  // reset synchroniser: only the second flop is read by the logic
  logic                             rstMeta_reg;
  logic                             rstSync_reg;
  logic                             rstSync_b;

  // convert-start edge detection and start qualification
  logic                             convPrev_reg;
  logic                             startFall;
  logic                             startRise;
  logic                             startAccept;

  // sequencer state and decoded phases
  acp_pkg::acp_state_type           state_reg;
  acp_pkg::acp_state_type           state_next;
  logic                             isIdle;
  logic                             converting;
  logic                             inEoc;

  // down-counters for conversion, hold window and end-of-conversion pulse
  logic [CW-1:0]                    convCnt_reg;
  logic [CW-1:0]                    convCnt_next;
  logic [CW-1:0]                    holdCnt_reg;
  logic [CW-1:0]                    holdCnt_next;
  logic [CW-1:0]                    eocCnt_reg;
  logic [CW-1:0]                    eocCnt_next;
  logic                             convLast;
  logic                             holdLast;
  logic                             eocLast;
  logic                             convDone;
  logic                             holdEnd;
  logic                             eocEnd;

  // track/hold and end-of-conversion outputs
  logic                             holdMode_reg;
  logic                             holdMode_next;
  logic                             eoc_n_reg;
  logic                             eoc_n_next;

  // successive-approximation datapath
  logic [RW-1:0]                    sampleHeld_reg;
  logic [RW-1:0]                    sampleHeld_next;
  logic [RW-1:0]                    sar_reg;
  logic [RW-1:0]                    sar_next;
  logic [RW-1:0]                    stepMask;
  logic [RW-1:0]                    trialWord;
  logic                             trialKeep;
  logic [RW-1:0]                    result_reg;
  logic [RW-1:0]                    result_next;

  // power-down bookkeeping
  logic                             convSleep_reg;
  logic                             convSleep_next;
  logic                             poweredDown_reg;
  logic                             poweredDown_next;

  // carrier between converter core and read port
  acp_port_if                       portBus ();

  // a counter has reached its final cycle when it shows one
  function automatic logic cnt_is_last(input logic [acp_pkg::CNT_WIDTH-1:0] cnt);
    return cnt == acp_pkg::CNT_ONE;
  endfunction

  // two-flop reset release; assertion is still immediate
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  assign rstSync_b = rstSync_reg;

  // edges of convert-start; the previous copy resets high, its idle level,
  // so leaving reset never fakes a rising edge
  assign startFall   = convPrev_reg & ~convert_start_n;
  assign startRise   = ~convPrev_reg & convert_start_n;
  // a start is taken only from idle and while powered
  assign startAccept = startFall & isIdle & ~poweredDown_reg & sleep_n;

  // phase decode
  assign isIdle     = (state_reg == acp_pkg::ACP_IDLE);
  assign converting = (state_reg == acp_pkg::ACP_CONVERT);
  assign inEoc      = (state_reg == acp_pkg::ACP_EOC);

  // counter end points
  assign convLast = cnt_is_last(convCnt_reg);
  assign holdLast = cnt_is_last(holdCnt_reg);
  assign eocLast  = cnt_is_last(eocCnt_reg);
  assign convDone = converting & convLast;
  assign holdEnd  = holdMode_reg & holdLast;
  assign eocEnd   = inEoc & eocLast;

  // sequencer: idle, convert for the full conversion time, then pulse
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      acp_pkg::ACP_IDLE:
        if (startAccept)
          state_next = acp_pkg::ACP_CONVERT;
      acp_pkg::ACP_CONVERT:
        if (convLast)
          state_next = acp_pkg::ACP_EOC;
      acp_pkg::ACP_EOC:
        if (eocLast)
          state_next = acp_pkg::ACP_IDLE;
      default:
        state_next = acp_pkg::ACP_IDLE;
    endcase
  end

  // counter next values; each loads on its starting event and counts down
  assign convCnt_next = startAccept ? acp_pkg::CONV_LOAD :
                        converting  ? convCnt_reg - acp_pkg::CNT_ONE :
                                      convCnt_reg;
  assign holdCnt_next = startAccept ? acp_pkg::HOLD_LOAD :
                        holdMode_reg ? holdCnt_reg - acp_pkg::CNT_ONE :
                                       holdCnt_reg;
  assign eocCnt_next  = convDone ? acp_pkg::EOC_LOAD :
                        inEoc    ? eocCnt_reg - acp_pkg::CNT_ONE :
                                   eocCnt_reg;

  // hold from the start edge; back to track after the hold window,
  // whether or not the conversion has finished
  assign holdMode_next = startAccept ? 1'b1 :
                         holdEnd     ? 1'b0 :
                                       holdMode_reg;

  // end-of-conversion pulse, active low, for the pulse-width count
  assign eoc_n_next = convDone ? 1'b0 :
                      eocEnd   ? 1'b1 :
                                 eoc_n_reg;

  // the held sample is frozen at the start edge
  assign sampleHeld_next = startAccept ? sampleCode : sampleHeld_reg;

  // one trial bit per conversion cycle, most significant first; this
  // relies on the conversion count equalling the result width
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < RW; bitIdx++)
    begin : g_sar_step
      localparam logic [CW-1:0] STEP_CODE = CW'(bitIdx + 1);
      assign stepMask[bitIdx] = converting & (convCnt_reg == STEP_CODE);
    end
  endgenerate

  // keep a trial bit only if the trial word does not exceed the sample
  assign trialWord = sar_reg | stepMask;
  assign trialKeep = (trialWord <= sampleHeld_reg);
  assign sar_next  = startAccept ? acp_pkg::RESULT_RESET :
                     (converting & trialKeep) ? trialWord :
                                                sar_reg;

  // holding register loads on the same edge that drops end-of-conversion,
  // so the strobe never precedes valid data; held until the next finish
  assign result_next = convDone ? sar_next : result_reg;

  // convert-start low at the finish powers down; set wins over the
  // rising edge that wakes the device
  assign convSleep_next   = (convDone & ~convert_start_n) |
                            (convSleep_reg & ~startRise);
  // the sleep pin acts on its own, whatever the sequencer is doing
  assign poweredDown_next = ~sleep_n | convSleep_next;

  // sequencer and edge detector flops
  always_ff @(posedge ref_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      state_reg    <= acp_pkg::ACP_IDLE;
      convPrev_reg <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      convPrev_reg <= convert_start_n;
    end
  end

  // timing counters
  always_ff @(posedge ref_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      convCnt_reg <= acp_pkg::CNT_ZERO;
      holdCnt_reg <= acp_pkg::CNT_ZERO;
      eocCnt_reg  <= acp_pkg::CNT_ZERO;
    end
    else
    begin
      convCnt_reg <= convCnt_next;
      holdCnt_reg <= holdCnt_next;
      eocCnt_reg  <= eocCnt_next;
    end
  end

  // output strobes and power state
  always_ff @(posedge ref_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      holdMode_reg    <= 1'b0;
      eoc_n_reg       <= 1'b1;
      convSleep_reg   <= 1'b0;
      poweredDown_reg <= 1'b0;
    end
    else
    begin
      holdMode_reg    <= holdMode_next;
      eoc_n_reg       <= eoc_n_next;
      convSleep_reg   <= convSleep_next;
      poweredDown_reg <= poweredDown_next;
    end
  end

  // conversion datapath
  always_ff @(posedge ref_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      sampleHeld_reg <= acp_pkg::RESULT_RESET;
      sar_reg        <= acp_pkg::RESULT_RESET;
      result_reg     <= acp_pkg::RESULT_RESET;
    end
    else
    begin
      sampleHeld_reg <= sampleHeld_next;
      sar_reg        <= sar_next;
      result_reg     <= result_next;
    end
  end

  // outputs straight from flops
  assign eocOut_n            = eoc_n_reg;
  assign holdMode            = holdMode_reg;
  assign poweredDown         = poweredDown_reg;
  assign portBus.heldResult  = result_reg;

  // parallel read port: chip select gating and bus drive
  acp_read_port readPort (
    .ref_clk      (ref_clk),
    .rstSync_b    (rstSync_b),
    .chipSel_n    (chipSel_n),
    .readStrobe_n (readStrobe_n),
    .channel_sel  (channel_sel),
    .portIf       (portBus.port),
    .resultOut    (resultOut),
    .resultOe     (resultOe),
    .chanSelected (chanSelected)
  );
endmodule // acp_converter

// >>> testbench/acp_converter_properties.sv
// port assertions for the converter control block
`timescale 1ns/10ps
module acp_converter_properties (input wire logic ref_clk, rst_b, convert_start_n, sleep_n,
  chipSel_n, readStrobe_n, eocOut_n, resultOe, holdMode, poweredDown,
  input wire logic [2:0] channel_sel, chanSelected);
  // sync reset copy lags rst_b, so early outputs are still reset values
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_oe_gated: assert property (resultOe |-> !chipSel_n && !readStrobe_n) else $error("oe");
  a_oe_drive: assert property (!chipSel_n && !readStrobe_n |-> ##[0:1] resultOe) else $error("rd");
  a_hold_start: assert property ($fell(convert_start_n) && !poweredDown |-> ##[0:2] holdMode)
    else $error("hold");
  a_hold_end: assert property ($rose(holdMode) |-> ##[1:4] !holdMode) else $error("track");
  a_eoc_after: assert property ($fell(convert_start_n) && !poweredDown |-> ##[6:12] !eocOut_n)
    else $error("eoc");
  a_eoc_width: assert property ($fell(eocOut_n) |-> !eocOut_n [*2]) else $error("width");
  a_sleep_down: assert property (!sleep_n |-> ##[0:2] poweredDown) else $error("pd");
  a_chan_cap: assert property ($fell(readStrobe_n) && !chipSel_n |-> ##1
    chanSelected == $past(channel_sel)) else $error("chan");
  c_eoc: cover property ($fell(eocOut_n));
  c_read: cover property ($rose(resultOe));
  c_pd: cover property ($rose(poweredDown));
endmodule // acp_converter_properties
bind acp_converter acp_converter_properties chk (.*);

// >>> testbench/acp_bus_model.sv
// host side data bus: a released line shows the inverse of its last value
`timescale 1ns/10ps
module acp_bus_model (input wire logic ref_clk, resultOe, input wire logic [7:0] resultOut,
  output logic [7:0] busLevel);
  logic [7:0] last_reg = 8'h00;
  always_ff @(posedge ref_clk) if (resultOe) last_reg <= resultOut;
  assign busLevel = resultOe ? resultOut : ~last_reg;
endmodule // acp_bus_model

// >>> testbench/acp_converter_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module acp_converter_tb;
  logic ref_clk = 0, rst_b = 0, convert_start_n = 1, sleep_n = 1, chipSel_n = 1, readStrobe_n = 1;
  logic [2:0] channel_sel = 3'h0, chanSelected;
  logic [7:0] sampleCode = 8'h00, resultOut, busLevel;
  logic eocOut_n, resultOe, holdMode, poweredDown;
  int errors = 0, checks = 0;
  always #25 ref_clk = ~ref_clk;
  acp_converter dut (.*);
  acp_bus_model bus (.*);
  task automatic chk(logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin errors++; $display("mismatch %0t %h %h", $time, got, exp); end
  endtask
  // one conversion, then a read on channel c
  task automatic t_conv(logic [7:0] v, logic [2:0] c);
    int n = 0;
    @(posedge ref_clk) begin sampleCode <= v; channel_sel <= c; convert_start_n <= 0; end
    @(posedge ref_clk) convert_start_n <= 1;
    while (eocOut_n !== 1'b0 && n < 20) begin @(negedge ref_clk); n++; end
    chk(n < 20, 1);
    @(posedge ref_clk) begin chipSel_n <= 0; readStrobe_n <= 0; end
    @(negedge ref_clk) chk(busLevel, v);
    @(posedge ref_clk) begin chipSel_n <= 1; readStrobe_n <= 1; end
    @(negedge ref_clk) chk(chanSelected, c);
  endtask
  task automatic t_cs;
    @(posedge ref_clk) readStrobe_n <= 0;
    repeat (2) @(negedge ref_clk);
    chk(resultOe, 0);
    @(posedge ref_clk) readStrobe_n <= 1;
  endtask
  task automatic t_sleep(logic s);
    @(posedge ref_clk) sleep_n <= s;
    repeat (3) @(negedge ref_clk);
    chk(poweredDown, !s);
  endtask
  // convert-start still low at conversion end; left last, as it is never raised to wake
  task automatic t_cvpd;
    @(posedge ref_clk) convert_start_n <= 0;
    repeat (16) @(negedge ref_clk);
    chk(poweredDown, 1);
  endtask
  task end_of_test;
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1;
    repeat (3) @(posedge ref_clk);
    t_conv(8'ha5, 3'h5); t_conv(8'h3c, 3'h2); t_cs; t_sleep(0); t_sleep(1); t_cvpd;
    end_of_test;
  end
  initial begin repeat (400) @(posedge ref_clk); errors++; end_of_test; end
endmodule // acp_converter_tb
